/* mmd_decoder.sv */
// mmd_decoder: flat 64k address decode, vector/stack flags, irq pin routing
// assumes the cpu core drives address and write strobes on I_SYS_CLK
//
// Overview of operation
// - one flat 64k space, memory and registers
// - registers, RAM, EEPROM each selectable region
// - user program region at most 8k
// - stack confined to 180h through 1FFh
// - top bytes hold reset and interrupt vectors
// - flash split in two upper sectors
// - sector zero, top of flash (F000h-FFFFh at the default 4k size), holds all vectors
// - sector zero size set by option byte
// - external irq routed to pin via select register
// - pin option bit chooses pull-up or floating
// - DEE0h-DEE3h return calibration in user mode
`timescale 1ns/1ns
module mmd_decoder #(
  parameter logic [31:0] CAL_VALUES = 32'h80808080
) (
  input  wire logic                                   I_SYS_CLK,
  input  wire logic                                   I_RST,
  input  wire logic [15:0]                            I_ADDR,
  input  wire logic                                   I_WR,
  input  wire logic [7:0]                             I_WDATA,
  input  wire logic                                   I_USER_MODE,
  input  wire logic [1:0]                             I_SEC0_SIZE,
  input  wire logic [mmd_pkg::NUM_PINS-1:0]           I_PINS,
  output mmd_pkg::mmd_sel_type                        O_SEL,
  output mmd_pkg::mmd_flag_type                       O_FLAG,
  output logic      [7:0]                             O_CAL_DATA,
  output logic      [mmd_pkg::NUM_XIRQ-1:0]           O_XIRQ,
  output logic      [mmd_pkg::NUM_PINS-1:0]           O_PULLUP_EN
);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [15:0] sec0_base(input logic [1:0] code);
    sec0_base = mmd_pkg::FLASH_LAST - (16'h0FFF >> code);
  endfunction

  // ------------------------------------------------------------
  // option byte capture after reset release
  // ------------------------------------------------------------
  logic [1:0] sec0_code_r;
  logic       opt_loaded_r;
  logic [15:0] sec0_lo;

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      sec0_code_r  <= mmd_pkg::SEC0_CODE_RST;
      opt_loaded_r <= 1'b0;
    end else if (!opt_loaded_r) begin
      sec0_code_r  <= I_SEC0_SIZE;
      opt_loaded_r <= 1'b1;
    end
  end

  assign sec0_lo = sec0_base(sec0_code_r);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic hit_reg;
  logic hit_ram;
  logic hit_ee;
  logic hit_fl;
  logic hit_cal;

  assign hit_reg = in_range(I_ADDR, mmd_pkg::REG_BASE, mmd_pkg::REG_LAST);
  assign hit_ram = in_range(I_ADDR, mmd_pkg::RAM_BASE, mmd_pkg::RAM_LAST);
  assign hit_ee  = in_range(I_ADDR, mmd_pkg::EE_BASE, mmd_pkg::EE_LAST);
  assign hit_fl  = in_range(I_ADDR, mmd_pkg::FLASH_BASE, mmd_pkg::FLASH_LAST);
  assign hit_cal = in_range(I_ADDR, mmd_pkg::CAL_BASE, mmd_pkg::CAL_LAST);

  always_comb begin
    O_SEL      = '0;
    O_SEL.regs = hit_reg;
    O_SEL.ram  = hit_ram;
    O_SEL.ee   = hit_ee;
    O_SEL.sec0 = hit_fl && (I_ADDR >= sec0_lo);
    O_SEL.sec1 = hit_fl && (I_ADDR < sec0_lo);
  end

  always_comb begin
    O_FLAG       = '0;
    O_FLAG.stack = in_range(I_ADDR, mmd_pkg::STACK_BASE, mmd_pkg::STACK_LAST);
    O_FLAG.vect  = I_ADDR >= mmd_pkg::VECT_BASE;
    O_FLAG.cal   = hit_cal && I_USER_MODE;
    O_FLAG.resv  = !(hit_reg || hit_ram || hit_ee || hit_fl) && !O_FLAG.cal;
  end

  // ------------------------------------------------------------
  // calibration bytes
  // ------------------------------------------------------------
  logic [7:0] cal_q;
  logic       cal_rd_r;

  mmd_cal_rom #(
    .CAL_VALUES (CAL_VALUES)
  ) u_cal (
    .i_clk  (I_SYS_CLK),
    .i_rst  (I_RST),
    .i_idx  (I_ADDR[1:0]),
    .o_data (cal_q)
  );

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      cal_rd_r <= 1'b0;
    end else begin
      cal_rd_r <= O_FLAG.cal;
    end
  end

  assign O_CAL_DATA = cal_rd_r ? cal_q : 8'h00;

  // ------------------------------------------------------------
  // irq pin select and pin option registers
  // ------------------------------------------------------------
  logic [11:0] xirq_sel_r;
  logic [7:0]  pin_opt_r;

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      xirq_sel_r <= mmd_pkg::XIRQ_SEL_RST;
    end else if (I_WR && I_ADDR == mmd_pkg::XIRQ_SEL_ADDR) begin
      xirq_sel_r <= {4'h0, I_WDATA};
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      pin_opt_r <= mmd_pkg::PIN_OPT_RST;
    end else if (I_WR && I_ADDR == mmd_pkg::PIN_OPT_ADDR) begin
      pin_opt_r <= I_WDATA;
    end
  end

  assign O_PULLUP_EN = pin_opt_r;

  // ------------------------------------------------------------
  // pin synchronisers and irq routing
  // ------------------------------------------------------------
  logic [mmd_pkg::NUM_PINS-1:0] pin_m_r;
  logic [mmd_pkg::NUM_PINS-1:0] pin_s_r;

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      pin_m_r <= '0;
      pin_s_r <= '0;
    end else begin
      pin_m_r <= I_PINS;
      pin_s_r <= pin_m_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < mmd_pkg::NUM_XIRQ; g++) begin : g_xirq
      logic [1:0] sel;
      assign sel = xirq_sel_r[2*g +: 2];
      always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
          O_XIRQ[g] <= 1'b0;
        end else begin
          O_XIRQ[g] <= pin_s_r[{sel, 1'b0} + 3'(g % 2)];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_one_hot_sel: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !O_FLAG.resv |-> $onehot(O_SEL) || O_FLAG.cal) else $error("select not one-hot");
  chk_vect_in_sec0: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_FLAG.vect |-> O_SEL.sec0) else $error("vector outside sector zero");
  chk_stack_in_ram: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_FLAG.stack |-> O_SEL.ram && I_ADDR[8:7] == 2'h3) else $error("stack outside bounds");
  chk_sec0_top: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (I_ADDR[15:9] == 7'h7F || (sec0_code_r == mmd_pkg::SEC0_CODE_RST && I_ADDR >= mmd_pkg::SEC0_DEF_BASE))
      |-> O_SEL.sec0 && !O_SEL.sec1) else $error("sector zero misses top of flash");
  chk_flash_size: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (O_SEL.sec0 || O_SEL.sec1) |-> I_ADDR >= mmd_pkg::FLASH_BASE) else $error("flash exceeds 8k");
  chk_cal_read: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_FLAG.cal |=> O_CAL_DATA == CAL_VALUES[{$past(I_ADDR[1:0]), 3'h0} +: 8]) else $error("cal byte wrong");
  chk_pullup_wr: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    I_WR && I_ADDR == mmd_pkg::PIN_OPT_ADDR |=> O_PULLUP_EN == $past(I_WDATA)) else $error("pin option not stored");
  chk_regs_range: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_SEL.regs |-> I_ADDR <= mmd_pkg::REG_LAST) else $error("register select out of range");

endmodule

/* mmd_pkg.sv */
// mmd_pkg: address map constants and carrier types for the memory map decoder
// assumes a 16-bit cpu address bus and a byte-wide data path
package mmd_pkg;

  // ------------------------------------------------------------
  // address space
  // ------------------------------------------------------------
  localparam int          ADDR_W        = 16;
  localparam logic [15:0] REG_BASE      = 16'h0000;
  localparam logic [15:0] REG_LAST      = 16'h007F;
  localparam logic [15:0] RAM_BASE      = 16'h0080;
  localparam logic [15:0] RAM_LAST      = 16'h01FF;
  localparam logic [15:0] STACK_BASE    = 16'h0180;
  localparam logic [15:0] STACK_LAST    = 16'h01FF;
  localparam logic [15:0] EE_BASE       = 16'h1000;
  localparam logic [15:0] EE_LAST       = 16'h10FF;
  localparam logic [15:0] FLASH_BASE    = 16'hE000;
  localparam logic [15:0] FLASH_LAST    = 16'hFFFF;
  localparam logic [15:0] SEC0_DEF_BASE = 16'hF000;
  localparam logic [15:0] VECT_BASE     = 16'hFFE0;
  localparam logic [15:0] CAL_BASE      = 16'hDEE0;
  localparam logic [15:0] CAL_LAST      = 16'hDEE3;
  localparam logic [15:0] XIRQ_SEL_ADDR = 16'h0030;
  localparam logic [15:0] PIN_OPT_ADDR  = 16'h0031;

  // ------------------------------------------------------------
  // option byte: sector 0 size code, 0=4k 1=2k 2=1k 3=0.5k
  // ------------------------------------------------------------
  localparam logic [1:0]  SEC0_CODE_RST = 2'h0;
  localparam int          NUM_XIRQ      = 4;
  localparam int          NUM_PINS      = 8;
  localparam int          PIN_SEL_W     = 3;
  localparam logic [7:0]  PIN_OPT_RST   = 8'h00;
  localparam logic [11:0] XIRQ_SEL_RST  = 12'h000;

  typedef struct packed {
    logic regs;
    logic ram;
    logic ee;
    logic sec0;
    logic sec1;
  } mmd_sel_type;

  typedef struct packed {
    logic stack;
    logic vect;
    logic cal;
    logic resv;
  } mmd_flag_type;

endpackage

/* mmd_cal_rom.sv */
// mmd_cal_rom: four calibration bytes, registered read data
// assumes the calibration values are fixed at build time
`timescale 1ns/1ns
module mmd_cal_rom #(
  parameter logic [31:0] CAL_VALUES = 32'h80808080
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_idx,
  output logic      [7:0] o_data
);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data <= 8'h00;
    end else begin
      o_data <= CAL_VALUES[{i_idx, 3'h0} +: 8];
    end
  end
endmodule

/* mmd_cpu_model.sv */
// mmd_cpu_model: cpu core side, drives address, strobe and write data
// assumes the bench calls one task per cycle
`timescale 1ns/1ns
module mmd_cpu_model (
  input  wire logic        i_clk,
  output logic      [15:0] o_addr,
  output logic             o_wr,
  output logic      [7:0]  o_wdata
);
  initial begin
    o_addr = 16'h0000;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  // one bus cycle; reserved places only when the bench asks for them
  task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wr <= w;
    o_wdata <= d;
  endtask
  // idle bus shows the inverse of the last address and data, strobe low
  task automatic idle();
    @(posedge i_clk);
    o_addr <= ~o_addr;
    o_wr <= 1'b0;
    o_wdata <= ~o_wdata;
  endtask
endmodule

/* mmd_decoder_test.sv */
// mmd_decoder_test: self-checking bench for the memory map decoder
// assumes one clock and the cpu model on the address side
`timescale 1ns/1ns
module mmd_decoder_test;
  typedef struct {int due; logic [28:0] m; logic [28:0] v;} mmd_note_type;
  localparam logic [31:0] CAL = 32'h44332211; // arbitrary
  logic                  clk, rst, um, wr;
  logic [15:0]           addr;
  logic [7:0]            wd, pins, cal_d, pu_en;
  logic [1:0]            code, opt;
  logic [3:0]            xirq;
  mmd_pkg::mmd_sel_type  sel;
  mmd_pkg::mmd_flag_type flag;
  mmd_note_type          q[$];
  int                    mismatches = 0, n_checks = 0, ncnt = 0, seed = 32'h41AF;
  logic [15:0]           pts [28] = '{16'h0000, 16'h007F, 16'h0080, 16'h017F, 16'h0180, 16'h01FF, 16'h0200,
    16'h0FFF, 16'h1000, 16'h10FF, 16'h1100, 16'hDEDF, 16'hDEE0, 16'hDEE3, 16'hDEE4, 16'hDFFF, 16'hE000,
    16'hEFFF, 16'hF000, 16'hF7FF, 16'hF800, 16'hFBFF, 16'hFC00, 16'hFDFF, 16'hFE00, 16'hFFDF, 16'hFFE0, 16'hFFFF};

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  mmd_decoder #(.CAL_VALUES(CAL)) u_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WR(wr), .I_WDATA(wd),
    .I_USER_MODE(um), .I_SEC0_SIZE(opt), .I_PINS(pins), .O_SEL(sel), .O_FLAG(flag), .O_CAL_DATA(cal_d),
    .O_XIRQ(xirq), .O_PULLUP_EN(pu_en));
  mmd_cpu_model u_cpu (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wd));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [28:0] seen, input logic [28:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic note(input int d, input logic [28:0] m, input logic [28:0] v);
    q.push_back('{ncnt + d, m, v & m});
  endtask
  function automatic logic [8:0] map(input logic [15:0] a, input logic [1:0] c, input logic u);
    logic [15:0] b;
    logic [4:0]  s;
    logic [3:0]  f;
    b = 16'hFFFF - (16'h1000 >> c) + 16'h0001;
    s = {a <= mmd_pkg::REG_LAST, a >= mmd_pkg::RAM_BASE && a <= mmd_pkg::RAM_LAST,
      a >= mmd_pkg::EE_BASE && a <= mmd_pkg::EE_LAST, a >= b, a >= mmd_pkg::FLASH_BASE && a < b};
    f[3] = a >= mmd_pkg::STACK_BASE && a <= mmd_pkg::STACK_LAST;
    f[2] = a >= mmd_pkg::VECT_BASE;
    f[1] = u && a >= mmd_pkg::CAL_BASE && a <= mmd_pkg::CAL_LAST;
    f[0] = s == 5'h00 && !f[1];
    return {s, f};
  endfunction
  task automatic acc(input logic [15:0] a, input logic u, input logic w, input logic [7:0] d);
    logic [8:0] e;
    u_cpu.access(a, w, d);
    um <= u;
    e = map(a, code, u);
    note(1, 29'h1FF00000, {e, 20'h00000});
    if (e[1]) note(2, 29'h000FF000, {9'h000, CAL[8*a[1:0] +: 8], 12'h000});
  endtask
  task automatic do_reset(input logic [1:0] c);
    // let the last pending note be compared before reset clears the outputs
    @(posedge clk);
    rst <= 1'b1;
    code <= c;
    opt <= c;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    opt <= ~c;
    note(1, 29'h000000FF, 29'h00000000);
  endtask
  task automatic wr_test();
    logic [7:0] s, p, pv;
    logic [3:0] x;
    s = 8'($random(seed));
    p = 8'($random(seed));
    pv = 8'($random(seed));
    for (int g = 0; g < 4; g++) x[g] = pv[{s[2*g +: 2], g[0]}];
    acc(mmd_pkg::XIRQ_SEL_ADDR, 1'b1, 1'b1, s);
    pins <= pv;
    acc(mmd_pkg::PIN_OPT_ADDR, 1'b1, 1'b1, p);
    note(2, 29'h000000FF, {21'h000000, p});
    repeat (5) u_cpu.idle();
    note(1, 29'h00000F00, {17'h00000, x, 8'h00});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    ncnt = ncnt + 1;
    while (q.size() > 0 && q[0].due <= ncnt) begin
      check({sel, flag, cal_d, xirq, pu_en} & q[0].m, q[0].v);
      void'(q.pop_front());
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    um = 1'b0;
    code = 2'h0;
    opt = 2'h0;
    pins = 8'h00;
    for (int c = 0; c < 4; c++) begin
      do_reset(c[1:0]);
      foreach (pts[i]) acc(pts[i], 1'b1, 1'b0, 8'h00);
      acc(mmd_pkg::CAL_BASE + 16'(c), 1'b0, 1'b0, 8'h00);
      for (int i = 0; i < 40; i++) acc(16'($random(seed)), 1'($random(seed)), 1'b0, 8'h00);
      for (int i = 0; i < 3; i++) wr_test();
    end
    repeat (4) u_cpu.idle();
    if (q.size() > 0) mismatches++;
    end_of_test();
  end
endmodule
